// file: host_model.sv
// Purpose: Host processor that kicks the watchdog
// Assumes: Kicks are level changes, not pulses
// Notes:   Reads the cause at each reset release
`timescale 1ns/1ps
module host_model
(
  input  wire logic clk,
  input  wire logic rst_out_n,
  input  wire logic flag_n,
  input  wire logic en,
  input  wire logic hz,
  output logic      kick,
  output logic      cause_wd
);
  logic       rst_q = 1'b0;
  logic [4:0] cnt_q = 5'h00;
  initial kick = 1'b0;
  initial cause_wd = 1'b0;
  always @(posedge clk)
  begin
    rst_q <= rst_out_n;
    cnt_q <= rst_out_n ? cnt_q + 5'h01 : 5'h00;
    if (rst_out_n && !rst_q)
      cause_wd <= !flag_n;
    // Kicks are whole level changes held for a kick period, except while hz is set, when the level toggles every cycle
    if (hz)
      kick <= !kick; // Released pin has no level, so keep it moving
    else if (en && cnt_q == 5'h13)
      kick <= !kick;
  end
endmodule // host_model

// file: rail_filter.sv
// Purpose: Glitch filter for one synchronised supply-low indication
// Assumes: Input already synchronised to CLOCK
// Notes:   Output changes only after FILT_CYCLES of steady input
`timescale 1ns/1ps
module rail_filter
  import supervisor_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic raw_low,
  output logic      filt_low
);
  logic [FILT_W-1:0] cnt_q;
  logic [FILT_W-1:0] cnt_d;
  logic              out_q;
  logic              out_d;

  always_comb
  begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (raw_low == out_q)
    begin
      cnt_d = '0;
    end
    else if (cnt_q == FILT_CYCLES - 4'h1)
    begin
      out_d = raw_low;
      cnt_d = '0;
    end
    else
    begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      out_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign filt_low = out_q;
endmodule // rail_filter

// file: sup_chk_props.sv
// Purpose: Port assertions for the supervisor
// Assumes: Bound to the top module
// Notes:   Figures follow the sim periods
`timescale 1ns/1ps
module sup_chk
  import supervisor_pkg::*;
#(
  parameter logic [31:0] HOLD_CYCLES = HOLD_CYCLES_DEF
)
(
  input wire logic                  CLOCK,
  input wire logic                  RSTN,
  input wire logic [RAIL_COUNT-1:0] SUPPLY_LOW,
  input wire logic                  KICK_INPUT,
  input wire logic                  KICK_HIGHZ,
  input wire logic                  DOG_PERIOD_CAP_PIN_GND,
  input wire logic                  RESET_N,
  input wire logic                  DOG_EXPIRED_N
);
  logic [31:0] low_run_q;

  // Run length of reset low; a counter keeps the hold check cheap for any period
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      low_run_q <= 32'h0000_0000;
    end
    else
    begin
      low_run_q <= RESET_N ? 32'h0000_0000 : low_run_q + 32'h0000_0001;
    end
  end

  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  property p_uv; (|SUPPLY_LOW)[*8] ##1 (|SUPPLY_LOW)[*4] |-> !RESET_N && DOG_EXPIRED_N;
  endproperty
  a_uv: assert property (p_uv) else $error("rail low not in reset");
  property p_hold; $rose(RESET_N) |-> low_run_q >= HOLD_CYCLES; endproperty
  a_hold: assert property (p_hold) else $error("hold too short");
  property p_run; $rose(RESET_N) |=> RESET_N[*8]; endproperty
  a_run: assert property (p_run) else $error("early timeout");
  property p_to; $fell(DOG_EXPIRED_N) |-> !RESET_N && $past(RESET_N)
    ##1 (!DOG_EXPIRED_N && !RESET_N)[*8]; endproperty
  a_to: assert property (p_to) else $error("timeout response");
  // Pin edge, two sync flops, then the flag register; reset must stay released
  property p_kick; RESET_N && !KICK_HIGHZ ##1 $changed(KICK_INPUT) && !KICK_HIGHZ
    ##2 RESET_N[*2] |-> DOG_EXPIRED_N; endproperty
  a_kick: assert property (p_kick) else $error("kick kept flag");
  property p_off; (KICK_HIGHZ || DOG_PERIOD_CAP_PIN_GND)[*8] |-> !$fell(DOG_EXPIRED_N);
  endproperty
  a_off: assert property (p_off) else $error("disabled dog fired");
  property p_hzd; $fell(KICK_HIGHZ) && !DOG_EXPIRED_N |-> !DOG_EXPIRED_N[*4]; endproperty
  a_hzd: assert property (p_hzd) else $error("driven pin cleared flag");
  // Any escape from the loop (kick, rail low, released or grounded pin) ends the wait
  property p_alt; $rose(RESET_N) && !DOG_EXPIRED_N
    |-> ##[1:60] ($fell(RESET_N) || DOG_EXPIRED_N || KICK_HIGHZ
    || DOG_PERIOD_CAP_PIN_GND); endproperty
  a_alt: assert property (p_alt) else $error("no repeat reset");
endmodule // sup_chk
bind supply_reset_watchdog_supervisor sup_chk #(.HOLD_CYCLES(HOLD_CYCLES)) chk (
  .CLOCK(CLOCK), .RSTN(RSTN), .SUPPLY_LOW(SUPPLY_LOW), .KICK_INPUT(KICK_INPUT),
  .KICK_HIGHZ(KICK_HIGHZ), .DOG_PERIOD_CAP_PIN_GND(DOG_PERIOD_CAP_PIN_GND),
  .RESET_N(RESET_N), .DOG_EXPIRED_N(DOG_EXPIRED_N));

// file: supervisor_pkg.sv
// Purpose: Shared constants for the supply reset and watchdog supervisor
// Assumes: 100 MHz system clock, six monitored rails
// Notes:   Periods are cycle counts standing in for timing capacitors
package supervisor_pkg;
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned RAIL_COUNT      = 6;
  localparam int unsigned CFG_W           = 4;
  localparam int unsigned CNT_W           = 32;
  localparam int unsigned FILT_W          = 4;
  localparam logic [3:0]  FILT_CYCLES     = 4'h8;
  localparam int unsigned KICK_MIN_US     = 2;
  localparam int unsigned KICK_MIN_CYCLES = KICK_MIN_US * CLK_MHZ;
  localparam logic [31:0] HOLD_CYCLES_DEF = 32'h0001_86A0;
  localparam logic [31:0] DOG_CYCLES_DEF  = 32'h000F_4240;
  localparam logic [31:0] CNT_ZERO        = 32'h0000_0000;

  typedef enum logic [1:0]
  {
    ST_LOW  = 2'b00,
    ST_HOLD = 2'b01,
    ST_RUN  = 2'b11
  } sup_state_t;
endpackage

// file: supply_reset_watchdog_supervisor.sv
// Purpose: Reset hold and watchdog supervision for a multi-rail monitor
// Assumes: Comparator outputs, kick and its high-z qualifier arrive as pins
// Notes:   Capacitor periods become cycle counts on the system clock
`timescale 1ns/1ps
// What this block does
// - Any rail low: reset output low, expiry flag forced high.
// - Rail low disables both timers and clears their counters.
// - Rails good: hold timer runs, reset stays low until it ends.
// - Watchdog counts after reset release; a kick edge restarts it unless expiry falls in the same cycle.
// - Timeout latches expiry flag low until rail low or valid kick.
// - Timeout asserts reset for one hold period, then releases it.
// - Kicks are ignored while reset is held and cannot clear the flag.
// - After release, a kick edge clears a latched-low expiry flag unless expiry falls in the same cycle.
// - High-impedance kick disables watchdog, clears count, keeps flag.
// - Latched flag without kicks makes hold and watchdog alternate.
// - Watchdog period pin grounded stops the watchdog timer; kick edges still clear the flag.
// - Any single rail low, even a pushbutton, runs the full reset.
// - One four-bit input picks one of sixteen threshold configurations.
// - Supply-low indications are glitch filtered before use.
// - High-z to driven kick starts the watchdog without clearing flag.
module supply_reset_watchdog_supervisor
  import supervisor_pkg::*;
#(
  parameter logic [31:0] HOLD_CYCLES = HOLD_CYCLES_DEF,
  parameter logic [31:0] DOG_CYCLES  = DOG_CYCLES_DEF
)
(
  input  wire logic                  CLOCK,
  input  wire logic                  RSTN,
  input  wire logic [RAIL_COUNT-1:0] SUPPLY_LOW,
  input  wire logic [CFG_W-1:0]      THRESH_SEL,
  input  wire logic                  KICK_INPUT,
  input  wire logic                  KICK_HIGHZ,
  input  wire logic                  DOG_PERIOD_CAP_PIN_GND,
  output logic [CFG_W-1:0]           THRESH_CFG,
  output logic                       RESET_N,
  output logic                       DOG_EXPIRED_N
);
  logic [RAIL_COUNT-1:0] low_s1_q;
  logic [RAIL_COUNT-1:0] low_s2_q;
  logic [RAIL_COUNT-1:0] low_filt;
  logic [2:0]            kick_s1_q;
  logic [2:0]            kick_s2_q;
  logic [CFG_W-1:0]      cfg_s1_q;
  logic                  kick_prev_q;
  logic                  hz_prev_q;
  logic                  supply_low;
  logic                  kick_edge;
  logic                  wd_off;
  sup_state_t            state_q;
  sup_state_t            state_d;
  logic [CNT_W-1:0]      cnt_q;
  logic [CNT_W-1:0]      cnt_d;
  logic                  exp_n_q;
  logic                  exp_n_d;
  logic                  rst_n_q;
  logic                  rst_n_d;
  logic [CFG_W-1:0]      cfg_q;

  // Counter step and end test are shared by the hold and the watchdog timer
  function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] cnt);
    count_up = cnt + 32'h0000_0001;
  endfunction

  // A period of zero wraps to the largest count, so periods must be one or more
  function automatic logic period_done
  (
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] period
  );
    period_done = (cnt >= period - 32'h0000_0001);
  endfunction

  // Two flops on every pin before any logic sees it
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      // Rails read as low until seen good, so nothing runs straight out of reset
      low_s1_q  <= '1;
      low_s2_q  <= '1;
      kick_s1_q <= 3'b010;
      kick_s2_q <= 3'b010;
    end
    else
    begin
      low_s1_q  <= SUPPLY_LOW;
      low_s2_q  <= low_s1_q;
      kick_s1_q <= {DOG_PERIOD_CAP_PIN_GND, KICK_HIGHZ, KICK_INPUT};
      kick_s2_q <= kick_s1_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < RAIL_COUNT; g++)
    begin : g_filt
      rail_filter u_filt
      (
        .clk      (CLOCK),
        .rst_n    (RSTN),
        .raw_low  (low_s2_q[g]),
        .filt_low (low_filt[g])
      );
    end
  endgenerate

  assign supply_low = |low_filt;
  assign wd_off     = kick_s2_q[1] | kick_s2_q[2];
  // hz_prev_q resets high, so the first samples after reset are never a kick
  // Edge only between two driven levels; leaving high-z is no kick
  assign kick_edge  = !kick_s2_q[1] && !hz_prev_q
                      && (kick_s2_q[0] != kick_prev_q);

  // One next-state block for timer, reset output and flag; rail low is applied
  // last so it overrides hold, run and timeout alike
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    exp_n_d = exp_n_q;
    rst_n_d = 1'b0;
    unique case (state_q)
      ST_LOW:
      begin
        cnt_d = CNT_ZERO;
        if (!supply_low)
        begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        // Kicks are ignored here so the flag survives one full hold
        if (period_done(cnt_q, HOLD_CYCLES))
        begin
          cnt_d   = CNT_ZERO;
          state_d = ST_RUN;
          rst_n_d = 1'b1;
        end
        else
        begin
          cnt_d = count_up(cnt_q);
        end
      end
      ST_RUN:
      begin
        rst_n_d = 1'b1;
        if (kick_edge)
        begin
          exp_n_d = 1'b1;
        end
        if (wd_off)
        begin
          cnt_d = CNT_ZERO;
        end
        else if (period_done(cnt_q, DOG_CYCLES))
        begin
          // Expiry and a kick in the same cycle: setting the flag wins
          cnt_d   = CNT_ZERO;
          exp_n_d = 1'b0;
          state_d = ST_HOLD;
          rst_n_d = 1'b0;
        end
        else if (kick_edge)
        begin
          cnt_d = CNT_ZERO;
        end
        else
        begin
          cnt_d = count_up(cnt_q);
        end
      end
      default:
      begin
        state_d = ST_LOW;
      end
    endcase
    // Rail low overrides everything
    if (supply_low)
    begin
      state_d = ST_LOW;
      cnt_d   = CNT_ZERO;
      exp_n_d = 1'b1;
      rst_n_d = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_q     <= ST_LOW;
      cnt_q       <= CNT_ZERO;
      exp_n_q     <= 1'b1;
      rst_n_q     <= 1'b0;
      kick_prev_q <= 1'b0;
      hz_prev_q   <= 1'b1;
      cfg_s1_q    <= '0;
      cfg_q       <= '0;
    end
    else
    begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      exp_n_q     <= exp_n_d;
      rst_n_q     <= rst_n_d;
      kick_prev_q <= kick_s2_q[0];
      hz_prev_q   <= kick_s2_q[1];
      // Threshold straps are pins too, so they pass the same two flops
      cfg_s1_q    <= THRESH_SEL;
      cfg_q       <= cfg_s1_q;
    end
  end

  assign THRESH_CFG    = cfg_q;
  assign RESET_N       = rst_n_q;
  assign DOG_EXPIRED_N = exp_n_q;
endmodule // supply_reset_watchdog_supervisor

// file: tb_top.sv
// Purpose: Self-checking bench for the supervisor
// Assumes: Hold 20 and watchdog 50 cycles
// Notes:   Kicks come from the host model
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
  $display("[ERR] %0t mismatch got %0h want %0h", $time, (a), (e)); end end
module tb_top;
  import supervisor_pkg::*;
  logic                  clk = 1'b0;
  logic                  rstn = 1'b0;
  logic [RAIL_COUNT-1:0] sup_low = '0; // Idle rails read good, as if tied to a supply
  logic [CFG_W-1:0]      sel = '0;
  logic                  hz = 1'b0;
  logic                  gnd = 1'b0;
  logic                  en = 1'b1;
  logic                  kick;
  logic                  cause_wd;
  logic [CFG_W-1:0]      cfg;
  logic                  rst_o_n;
  logic                  flag_n;
  int                    compares = 0;
  int                    miscompares = 0;
  always #5 clk = ~clk;
  supply_reset_watchdog_supervisor #(.HOLD_CYCLES(32'h0000_0014), .DOG_CYCLES(32'h0000_0032)) dut (
    .CLOCK(clk), .RSTN(rstn), .SUPPLY_LOW(sup_low), .THRESH_SEL(sel), .KICK_INPUT(kick),
    .KICK_HIGHZ(hz), .DOG_PERIOD_CAP_PIN_GND(gnd), .THRESH_CFG(cfg), .RESET_N(rst_o_n),
    .DOG_EXPIRED_N(flag_n));
  host_model host (.clk(clk), .rst_out_n(rst_o_n), .flag_n(flag_n), .en(en), .hz(hz),
    .kick(kick), .cause_wd(cause_wd));
  task test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input int n, ref logic s, input logic v);
    repeat (n) if (s !== v) @(negedge clk);
    `CHK(s, v)
  endtask
  task t_uv;
    for (int k = 0; k < RAIL_COUNT; k++)
    begin
      @(posedge clk);
      sup_low <= 6'h01 << k;
      wt(15);
      `CHK({rst_o_n, flag_n}, 2'b01)
      @(posedge clk);
      sup_low <= '0;
      wt(25);
      `CHK(rst_o_n, 1'b0)
      wt(10);
      `CHK({rst_o_n, cause_wd}, 2'b10)
    end
  endtask
  task t_glitch;
    @(posedge clk);
    sup_low <= 6'h20;
    wt(5);
    @(posedge clk);
    sup_low <= '0;
    wt(20);
    `CHK(rst_o_n, 1'b1)
  endtask
  task t_cfg;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      sel <= CFG_W'(i);
      wt(3);
      `CHK(cfg, CFG_W'(i))
    end
  endtask
  task t_off;
    @(posedge clk);
    gnd <= 1'b1;
    en <= 1'b0;
    wt(120);
    `CHK({rst_o_n, flag_n}, 2'b11)
    @(posedge clk);
    gnd <= 1'b0;
    en <= 1'b1;
  endtask
  task t_dog;
    @(posedge clk);
    en <= 1'b0;
    wr(80, flag_n, 1'b0);
    `CHK(rst_o_n, 1'b0)
    wr(30, rst_o_n, 1'b1);
    `CHK(flag_n, 1'b0)
    wr(60, rst_o_n, 1'b0);
    wr(30, rst_o_n, 1'b1);
    @(posedge clk);
    hz <= 1'b1;
    // Watch every cycle: a live watchdog would pull reset low inside the window
    repeat (100)
    begin
      @(negedge clk);
      `CHK(rst_o_n, 1'b1)
    end
    `CHK({rst_o_n, flag_n}, 2'b10)
    @(posedge clk);
    hz <= 1'b0;
    wt(10);
    `CHK(flag_n, 1'b0)
    @(posedge clk);
    en <= 1'b1;
    wr(40, flag_n, 1'b1);
    `CHK(cause_wd, 1'b1)
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    wr(60, rst_o_n, 1'b1);
    t_uv;
    t_glitch;
    t_cfg;
    t_off;
    t_dog;
    test_done;
  end
  initial
  begin
    #100us;
    $display("[ERR] %0t timeout", $time);
    miscompares++;
    test_done;
  end
endmodule // tb_top
